/* File: src/scu_spi_uart.sv */
// spi-attached uart: command port, baud generator, transmitter, receiver
`timescale 1ns/1ns
`include "scu_defines.svh"
module scu_spi_uart
  import scu_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  output logic      irq_n,
  output logic      tx,
  input  wire logic rx,
  output logic      rts_n,
  input  wire logic cts_n
);

  function automatic logic [8:0] scu_ratio(input logic [3:0] code);
    logic [8:0] base;
    base = code[3] ? 9'h003 : 9'h001;
    return base << code[2:0];
  endfunction

  // ---------------- command port ----------------
  logic        cs_q, cs_d, sclk_q, sclk_d, miso_q, miso_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] sin_q, sin_d, resp_q, resp_d;
  logic        cs_fall, cs_rise, sck_rise, sck_fall, cmd_ok;
  logic [1:0]  op, early_op;
  logic        do_wcfg, do_wdata, do_data;
  logic        shdn_q, shdn_d;
  logic [13:0] cfg_q, cfg_d;
  logic        r_flag, t_flag, err_flag;
  logic [8:0]  head;

  assign cs_fall  = cs_q & ~cs_n;
  assign cs_rise  = ~cs_q & cs_n;
  assign sck_rise = ~cs_n & sclk & ~sclk_q;
  assign sck_fall = ~cs_n & ~sclk & sclk_q;
  assign cmd_ok   = cs_rise & (cnt_q == `SCU_WORD_BITS); // R20
  assign op       = sin_q[15:14]; // R1
  assign early_op = {sin_q[0], mosi};
  assign do_wcfg  = cmd_ok & (op == `SCU_OP_WR_CFG);
  assign do_wdata = cmd_ok & (op == `SCU_OP_WR_DATA);
  assign do_data  = cmd_ok & ~op[0];

  always_comb begin
    cs_d   = cs_n;
    sclk_d = sclk;
    cnt_d  = cnt_q;
    sin_d  = sin_q;
    resp_d = resp_q;
    miso_d = miso_q;
    if (cs_fall) begin
      cnt_d  = 5'h00;
      resp_d = {r_flag, t_flag, 14'h0000}; // R4
      miso_d = r_flag;
    end else if (sck_rise && cnt_q != `SCU_WORD_BITS) begin
      sin_d = {sin_q[14:0], mosi}; // R20
      cnt_d = cnt_q + 5'h01;
      // the operation is known after two bits, in time for bit 13
      if (cnt_q == 5'h01) begin
        case (early_op)
          `SCU_OP_RD_CFG: begin
            resp_d[13:0] = cfg_q; // R5
            resp_d[`SCU_CFG_SHDN] = shdn_q; // R5
          end
          `SCU_OP_WR_CFG: resp_d[13:0] = 14'h0000; // R5
          default: resp_d[13:0] = {3'h0, err_flag, ~cts_n, head}; // R6
        endcase
      end
    end else if (sck_fall) begin
      miso_d = (cnt_q == `SCU_WORD_BITS) ? 1'b0 : resp_q[4'hF - cnt_q[3:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
      cnt_q  <= 5'h00;
      sin_q  <= 16'h0000;
      resp_q <= 16'h0000;
      miso_q <= 1'b0;
    end else begin
      cs_q   <= cs_d;
      sclk_q <= sclk_d;
      cnt_q  <= cnt_d;
      sin_q  <= sin_d;
      resp_q <= resp_d;
      miso_q <= miso_d;
    end
  end

  assign miso    = miso_q;
  assign miso_oe = ~cs_n;

  // ---------------- configuration and control ----------------
  logic rts_n_q, rts_n_d, inh_q, inh_d, tx_busy;
  logic tbuf_v_q, tbuf_v_d;

  always_comb begin
    cfg_d   = cfg_q;
    rts_n_d = rts_n_q;
    inh_d   = inh_q;
    if (do_wcfg) cfg_d = sin_q[13:0]; // R2
    if (do_wdata) begin
      inh_d   = sin_q[`SCU_WD_INHIBIT]; // R3
      rts_n_d = ~sin_q[`SCU_WD_RTS]; // R19
    end
    // shutdown only once both the shifter and the buffer are drained
    shdn_d = cfg_q[`SCU_CFG_SHDN] & (shdn_q | (~tx_busy & ~tbuf_v_q)); // R17
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= `SCU_CFG_RESET;
      rts_n_q <= 1'b1;
      inh_q   <= 1'b0;
      shdn_q  <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      rts_n_q <= rts_n_d;
      inh_q   <= inh_d;
      shdn_q  <= shdn_d;
    end
  end

  assign rts_n = rts_n_q;

  // ---------------- baud generator ----------------
  logic [8:0] div_q, div_d;
  logic       tick;

  assign tick = ~shdn_q & (div_q == scu_ratio(cfg_q[3:0]) - 9'h001); // R16

  always_comb begin
    div_d = div_q + 9'h001;
    if (tick || shdn_q || do_wcfg) div_d = 9'h000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_q <= 9'h000;
    else        div_q <= div_d;
  end

  // ---------------- transmitter ----------------
  scu_tx_state_t tst_q, tst_d;
  logic [8:0]    tbuf_q, tbuf_d, tsh_q, tsh_d;
  logic [3:0]    tph_q, tph_d, tbit_q, tbit_d;
  logic          tx_q, tx_d, tbit_val, tirq_q, tirq_d;

  assign tx_busy = (tst_q != TX_IDLE);

  always_comb begin
    tst_d    = tst_q;
    tsh_d    = tsh_q;
    tph_d    = tph_q;
    tbit_d   = tbit_q;
    tbuf_d   = tbuf_q;
    tbuf_v_d = tbuf_v_q;
    tirq_d   = tirq_q;
    case (tst_q)
      TX_START: tbit_val = 1'b0;
      TX_DATA:  tbit_val = tsh_q[tbit_q[2:0]];
      TX_PAR:   tbit_val = tsh_q[8]; // R7
      default:  tbit_val = 1'b1;
    endcase
    if (tick) begin
      tph_d = tph_q + 4'h1;
      case (tst_q)
        TX_IDLE: begin
          tph_d = 4'h0;
          if (tbuf_v_q) begin
            tsh_d    = tbuf_q;
            tbuf_v_d = 1'b0;
            tst_d    = TX_START;
          end
        end
        TX_START: if (tph_q == `SCU_PH_LAST) begin
          tst_d  = TX_DATA;
          tbit_d = 4'h0;
        end
        TX_DATA: if (tph_q == `SCU_PH_LAST) begin
          tbit_d = tbit_q + 4'h1;
          if (tbit_q == (cfg_q[`SCU_CFG_L] ? 4'h6 : 4'h7)) begin
            tst_d  = cfg_q[`SCU_CFG_PE] ? TX_PAR : TX_STOP;
            tbit_d = 4'h0;
          end
        end
        TX_PAR: if (tph_q == `SCU_PH_LAST) tst_d = TX_STOP;
        TX_STOP: if (tph_q == `SCU_PH_LAST) begin
          tbit_d = tbit_q + 4'h1;
          if (tbit_q == {3'h0, cfg_q[`SCU_CFG_ST]}) tst_d = TX_IDLE;
        end
        default: tst_d = TX_IDLE;
      endcase
    end
    // a hand-over in the same cycle as the clearing read must not be lost
    if (cmd_ok && op == `SCU_OP_RD_DATA) tirq_d = 1'b0;
    if (tbuf_v_q && !tbuf_v_d) tirq_d = 1'b1;
    if (do_wdata && !sin_q[`SCU_WD_INHIBIT]) begin // R3
      tbuf_d   = sin_q[8:0];
      tbuf_v_d = 1'b1;
    end
    // line output; infrared shortens each zero to a 3/16 low pulse
    if (inh_q) tx_d = 1'b1;
    else if (cfg_q[`SCU_CFG_IR])
      tx_d = tbit_val | (tph_q >= `SCU_IR_PULSE); // R10 R11
    else tx_d = tbit_val;
    if (shdn_q) begin
      tst_d    = TX_IDLE;
      tbuf_v_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tst_q    <= TX_IDLE;
      tsh_q    <= 9'h000;
      tph_q    <= 4'h0;
      tbit_q   <= 4'h0;
      tbuf_q   <= 9'h000;
      tbuf_v_q <= 1'b0;
      tirq_q   <= 1'b0;
      tx_q     <= 1'b1;
    end else begin
      tst_q    <= tst_d;
      tsh_q    <= tsh_d;
      tph_q    <= tph_d;
      tbit_q   <= tbit_d;
      tbuf_q   <= tbuf_d;
      tbuf_v_q <= tbuf_v_d;
      tirq_q   <= tirq_d;
      tx_q     <= tx_d;
    end
  end

  assign tx     = tx_q;
  assign t_flag = ~tbuf_v_q;

  // ---------------- receiver and two-entry buffer ----------------
  scu_rx_state_t rst_q, rst_d;
  logic [8:0] rsh_q, rsh_d;
  logic [3:0] rph_q, rph_d, rbit_q, rbit_d;
  logic [1:0] vote_q, vote_d, run_q, run_d, fcnt_q, fcnt_d;
  logic       hit_q, hit_d, fe_q, fe_d, ovr_q, ovr_d, cpar_q, cpar_d;
  logic       line_zero, bit_val, push, push_ready, pop;
  logic [8:0] mem_q [0:1];
  logic [8:0] mem_d [0:1];
  logic       wp_q, wp_d, rp_q, rp_d;

  // in infrared mode a high pulse on rx means zero
  assign line_zero  = cfg_q[`SCU_CFG_IR] ? rx : ~rx; // R11
  assign bit_val    = cfg_q[`SCU_CFG_IR] ? ~hit_q : ~vote_q[1]; // R12
  assign push_ready = (fcnt_q == 2'h0) | (~cfg_q[`SCU_CFG_FIFO_DIS] & (fcnt_q == 2'h1));
  assign pop        = do_data & r_flag;
  assign r_flag     = (fcnt_q != 2'h0);
  assign head       = mem_q[rp_q];
  assign err_flag   = fe_q | ovr_q;

  always_comb begin
    rst_d  = rst_q;
    rsh_d  = rsh_q;
    rph_d  = rph_q;
    rbit_d = rbit_q;
    vote_d = vote_q;
    run_d  = run_q;
    hit_d  = hit_q;
    fe_d   = fe_q;
    cpar_d = cpar_q;
    push   = 1'b0;
    if (tick) begin
      // glitch filter: a pulse counts only from its second tick on
      run_d = line_zero ? ((run_q == `SCU_IR_MIN_RUN) ? run_q : run_q + 2'h1) : 2'h0; // R13
      rph_d = rph_q + 4'h1;
      if (line_zero && run_q == `SCU_IR_MIN_RUN) hit_d = 1'b1; // R12 R13
      if (rph_q >= `SCU_VOTE_FIRST && rph_q <= `SCU_VOTE_LAST && line_zero)
        vote_d = vote_q + 2'h1;
      case (rst_q)
        RX_IDLE: begin
          vote_d = 2'h0;
          hit_d  = 1'b0;
          if (cfg_q[`SCU_CFG_IR] ? (line_zero && run_q == `SCU_IR_MIN_RUN) : line_zero) begin
            rst_d = RX_START;
            rph_d = cfg_q[`SCU_CFG_IR] ? 4'h2 : 4'h1;
            hit_d = cfg_q[`SCU_CFG_IR];
          end
        end
        default: if (rph_q == `SCU_PH_LAST) begin
          vote_d = 2'h0;
          hit_d  = 1'b0;
          case (rst_q)
            RX_START: begin
              rst_d  = bit_val ? RX_IDLE : RX_DATA;
              rbit_d = 4'h0;
              rsh_d  = 9'h000;
            end
            RX_DATA: begin
              rsh_d[rbit_q[2:0]] = bit_val;
              rbit_d = rbit_q + 4'h1;
              if (rbit_q == (cfg_q[`SCU_CFG_L] ? 4'h6 : 4'h7))
                rst_d = cfg_q[`SCU_CFG_PE] ? RX_PAR : RX_STOP;
            end
            RX_PAR: begin
              rsh_d[8] = bit_val; // R7
              rst_d    = RX_STOP;
            end
            default: begin
              rst_d  = RX_IDLE;
              push   = 1'b1;
              fe_d   = ~bit_val; // R18
              cpar_d = rsh_q[8]; // R9
            end
          endcase
        end
      endcase
    end
    if (pop) cpar_d = push ? rsh_q[8] : 1'b0;
    if (shdn_q) begin
      rst_d  = RX_IDLE;
      fe_d   = 1'b0;
      cpar_d = 1'b0;
    end
  end

  // the line cannot be stalled, so a word refused by a full buffer counts as overrun
  always_comb begin
    mem_d  = mem_q;
    wp_d   = wp_q;
    rp_d   = rp_q;
    fcnt_d = fcnt_q;
    ovr_d  = ovr_q;
    if (pop) begin
      rp_d   = ~rp_q;
      fcnt_d = fcnt_d - 2'h1;
      ovr_d  = 1'b0;
    end
    if (push && push_ready) begin
      mem_d[wp_q] = rsh_q;
      wp_d        = ~wp_q;
      fcnt_d      = fcnt_d + 2'h1;
    end else if (push) begin
      ovr_d = 1'b1;
    end
    if (shdn_q) begin
      fcnt_d = 2'h0;
      rp_d   = wp_q;
      ovr_d  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q  <= RX_IDLE;
      rsh_q  <= 9'h000;
      rph_q  <= 4'h0;
      rbit_q <= 4'h0;
      vote_q <= 2'h0;
      run_q  <= 2'h0;
      hit_q  <= 1'b0;
      fe_q   <= 1'b0;
      cpar_q <= 1'b0;
      mem_q  <= '{default: 9'h000};
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      fcnt_q <= 2'h0;
      ovr_q  <= 1'b0;
    end else begin
      rst_q  <= rst_d;
      rsh_q  <= rsh_d;
      rph_q  <= rph_d;
      rbit_q <= rbit_d;
      vote_q <= vote_d;
      run_q  <= run_d;
      hit_q  <= hit_d;
      fe_q   <= fe_d;
      cpar_q <= cpar_d;
      mem_q  <= mem_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      fcnt_q <= fcnt_d;
      ovr_q  <= ovr_d;
    end
  end

  // ---------------- interrupt request ----------------
  assign irq_n = ~((cfg_q[`SCU_CFG_PARIE] & cpar_q) // R8 R9
                 | (cfg_q[`SCU_CFG_RXIE] & r_flag)
                 | (cfg_q[`SCU_CFG_TXIE] & tirq_q)
                 | (cfg_q[`SCU_CFG_FEIE] & err_flag));

endmodule

/* File: src/scu_defines.svh */
// command, field and timing constants of the serial-command uart
// What this block does
// [R1] bits 15:14 select one of four operations
// [R2] config write loads all configuration fields
// [R3] data write loads inhibit, rts, parity, byte
// [R4] every reply carries receive and transmit flags
// [R5] config read echoes fields, bit 12 shutdown status
// [R6] data replies carry error, cts, parity, byte
// [R7] multidrop frames eight data bits plus parity
// [R8] parity interrupt fires on received parity one
// [R9] parity interrupt follows receive register only
// [R10] infrared transmit pulses last three sixteenths
// [R11] infrared zero drives tx low, rx high
// [R12] infrared receive latches a pulse anywhere in the bit
// [R13] infrared receive rejects pulses under one sixteenth
// [R14] infrared partner sends three-sixteenth pulses
// [R15] infrared host uses eight bits, no parity
// [R16] baud equals clock over sixteen times ratio
// [R17] shutdown waits until transmitter fully drained
// [R18] framing flag set on bad stop, cleared next good
// [R19] rts bit one drives rts pin low
// [R20] cs low frames sixteen msb-first bits
`ifndef SCU_DEFINES_SVH
`define SCU_DEFINES_SVH

`define SCU_OP_WR_CFG   2'h3
`define SCU_OP_RD_CFG   2'h1
`define SCU_OP_WR_DATA  2'h2
`define SCU_OP_RD_DATA  2'h0

`define SCU_CFG_FIFO_DIS 13
`define SCU_CFG_SHDN     12
`define SCU_CFG_TXIE     11
`define SCU_CFG_RXIE     10
`define SCU_CFG_PARIE    9
`define SCU_CFG_FEIE     8
`define SCU_CFG_IR       7
`define SCU_CFG_ST       6
`define SCU_CFG_PE       5
`define SCU_CFG_L        4
`define SCU_CFG_RESET    14'h0000

`define SCU_WD_INHIBIT   10
`define SCU_WD_RTS       9
`define SCU_WD_PAR       8
`define SCU_RESP_R       15
`define SCU_RESP_T       14

`define SCU_WORD_BITS    5'h10
`define SCU_PH_LAST      4'hF
`define SCU_VOTE_FIRST   4'h7
`define SCU_VOTE_LAST    4'h9
`define SCU_IR_PULSE     4'h3
`define SCU_IR_MIN_RUN   2'h1

`endif

/* File: src/scu_pkg.sv */
// state types of the serial-command uart
package scu_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scu_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scu_rx_state_t;
endpackage

/* File: test/scu_spi_uart_sva.sv */
// assertion checker bound to the serial-command uart top
`timescale 1ns/1ns
module scu_spi_uart_chk (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic irq_n,
  input  wire logic tx,
  input  wire logic rx,
  input  wire logic rts_n,
  input  wire logic cts_n
);
  logic [15:0] lo_run_d;
  logic [15:0] lo_run_q;
  logic [15:0] hi_run_d;
  logic [15:0] hi_run_q;

  // run lengths of the tx line, saturating so a long idle cannot wrap
  always_comb begin
    lo_run_d = tx ? 16'h0000 : lo_run_q + {15'h0000, lo_run_q != 16'hFFFF};
    hi_run_d = tx ? hi_run_q + {15'h0000, hi_run_q != 16'hFFFF} : 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_run_q <= 16'h0000;
      hi_run_q <= 16'h0000;
    end else begin
      lo_run_q <= lo_run_d;
      hi_run_q <= hi_run_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_oe_tracks_cs: assert property (miso_oe == !cs_n)
    else $error("miso_oe not tracking cs_n");
  a_miso_held_high: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
  a_miso_after_fall: assert property (!cs_n && $changed(miso) |-> !$past(sclk))
    else $error("miso moved without sclk fall");
  a_rts_after_frame: assert property ($changed(rts_n) |-> cs_n && $past(cs_n))
    else $error("rts_n moved inside a frame");
  a_reset_idle: assert property ($rose(rst_n) |-> tx && rts_n && irq_n && !miso)
    else $error("outputs not idle after reset");
  // a low run is whole bits in normal mode, 3/16 of a bit in infrared mode
  a_tx_pulse_width: assert property ($rose(tx) |->
    (lo_run_q[3:0] == 4'h0) || (lo_run_q % 3 == 0))
    else $error("tx low run of odd length");
  a_tx_gap_min: assert property ($fell(tx) |-> hi_run_q >= 16'd13)
    else $error("tx high gap too short");
  a_tx_low_min: assert property ($fell(tx) |=> !tx [*2])
    else $error("tx pulse shorter than three clocks");

  c_frame: cover property ($fell(cs_n));
  c_irq: cover property ($fell(irq_n));
  c_ir_pulse: cover property ($rose(tx) && lo_run_q == 16'h0003);
  c_rts: cover property ($changed(rts_n));
endmodule

bind scu_spi_uart scu_spi_uart_chk scu_spi_uart_chk_i (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .irq_n(irq_n), .tx(tx), .rx(rx), .rts_n(rts_n), .cts_n(cts_n)
);

/* File: test/scu_host_model.sv */
// host-side spi master model for the serial-command uart
`timescale 1ns/1ns
module scu_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // one word each way, msb first; sclk phases kept well above two clocks
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    tick(1);
    cs_n = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      mosi = w[i];
      tick(2);
      sclk = 1'b1;
      r[i] = miso;
      tick(3);
      sclk = 1'b0;
      mosi = ~w[i];
      tick(4);
    end
    cs_n = 1'b1;
    tick(3);
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench of the serial-command uart with a host model
`timescale 1ns/1ns
module testbench;
  typedef struct {
    logic [15:0] cmd;
    logic [15:0] exp;
    logic        rts_n;
  } scu_row_t;
  localparam logic [10:0] TX_FRAME = {2'h3, 8'h55, 1'h0};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rx = 1'b1;
  logic        cts_n = 1'b0;
  logic        cs_n, sclk, mosi, miso, miso_oe, irq_n, tx, rts_n;
  logic [15:0] r;
  int          k;
  int          failures = 0;
  int          n_compared = 0;
  scu_row_t    rows [7] = '{
    '{16'h4000, 16'h4000, 1'b1},
    '{16'hC221, 16'h4000, 1'b1},
    '{16'h4001, 16'h4221, 1'b1},
    '{16'h0000, 16'h4200, 1'b1},
    '{16'h8600, 16'h4200, 1'b0},
    '{16'h8400, 16'h4200, 1'b1},
    '{16'h0000, 16'h4200, 1'b1}
  };

  scu_spi_uart scu_spi_uart_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .irq_n(irq_n), .tx(tx), .rx(rx),
    .rts_n(rts_n), .cts_n(cts_n));
  scu_host_model scu_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso));

  always #50 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic xf(input logic [15:0] w);
    scu_host_model_i.xfer(w, r);
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_fall;
    k = 0;
    while (tx !== 1'b0 && k < 9000) begin
      tick(1);
      k++;
    end
  endtask

  // b[0] goes first; infrared bits are 16 clocks long at ratio 1
  task automatic send_rx(input logic [10:0] b, input int n, input int bt, input logic ir);
    for (int i = 0; i < n; i++) begin
      if (ir) begin
        rx = ~b[i];
        tick(3);
        rx = 1'b0;
        tick(5);
        rx = b[i];
        tick(1);
        rx = 1'b0;
        tick(7);
      end else begin
        rx = b[i];
        tick(bt);
      end
    end
  endtask

  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    tick(4);
    rst_n = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      xf(rows[i].cmd);
      chk("reply", rows[i].exp, r);
      tick(4);
      chk("rts_n", {15'h0000, rows[i].rts_n}, {15'h0000, rts_n});
    end
    xf(16'h8155);
    wait_fall();
    tick(15);
    for (int i = 0; i < 11; i++) begin
      chk("tx bit", {15'h0000, TX_FRAME[i]}, {15'h0000, tx});
      tick(32);
    end
    send_rx({2'h3, 8'hA5, 1'h0}, 11, 32, 1'b0);
    tick(4);
    chk("irq_n", 16'h0000, {15'h0000, irq_n});
    xf(16'h0000);
    chk("rx word", 16'hC3A5, r);
    tick(4);
    chk("irq_n", 16'h0001, {15'h0000, irq_n});
    // stop bit held low only past its sample point, so no false start follows
    send_rx({2'h0, 8'h3C, 1'h0}, 10, 32, 1'b0);
    rx = 1'b0;
    tick(20);
    rx = 1'b1;
    tick(40);
    xf(16'h0000);
    chk("framing", 16'hC63C, r);
    send_rx({2'h2, 8'h3C, 1'h0}, 11, 32, 1'b0);
    tick(20);
    xf(16'h0000);
    chk("framing", 16'hC23C, r);
    xf(16'hC080);
    rx = 1'b0;
    tick(200);
    xf(16'h0000);
    send_rx({2'h1, 8'h96, 1'h0}, 10, 16, 1'b1);
    tick(20);
    xf(16'h0000);
    chk("ir rx", 16'hC296, r & 16'hFEFF);
    xf(16'h80F0);
    repeat (2) begin
      wait_fall();
      k = 0;
      while (tx === 1'b0 && k < 50) begin
        tick(1);
        k++;
      end
    end
    chk("ir pulse", 16'h0003, k[15:0]);
    cts_n = 1'b1;
    xf(16'h0000);
    chk("cts", 16'h4000, r & 16'hFE00);
    close_out();
  end

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule
